/* File: position_latch_pkg.sv */
package position_latch_pkg;

	// object indexes seen over the link
	localparam logic [15:0] IDX_FUNC_EXP3 = 16'h3697;
	localparam logic [15:0] IDX_TRIM_ONE = 16'h3709;
	localparam logic [15:0] IDX_COMM_PROBE_ONE_INPUT = 16'h3722;
	localparam logic [15:0] IDX_TRIM_TWO = 16'h3792;
	localparam logic [15:0] IDX_PROBE_EXP = 16'h4304;
	localparam logic [15:0] IDX_SCALE_MON = 16'h4F0D;
	localparam logic [15:0] IDX_SCALE_TOTAL = 16'h4F48;
	localparam logic [15:0] IDX_SCALE_P1_RISE = 16'h4F4B;
	localparam logic [15:0] IDX_SCALE_P1_FALL = 16'h4F4C;
	localparam logic [15:0] IDX_SCALE_P2_RISE = 16'h4F4D;
	localparam logic [15:0] IDX_SCALE_P2_FALL = 16'h4F4E;
	localparam logic [15:0] IDX_PROBE_CTRL = 16'h60B8;
	localparam logic [15:0] IDX_PROBE_STATUS = 16'h60B9;
	localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
	localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
	localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
	localparam logic [15:0] IDX_P2_FALL = 16'h60BD;

	// control field positions within one probe's byte, the stride between probes and the scale clear bit of the word
	localparam int CTL_ENABLE = 0;
	localparam int CTL_CONT = 1;
	localparam int CTL_ZSEL = 2;
	localparam int CTL_RISE = 4;
	localparam int CTL_FALL = 5;
	localparam int CTL_PROBE_STRIDE = 8;
	localparam int CTL_SCALE_CLEAR = 15;

	// setup bits
	localparam int COMM_SCALE_MON_BIT = 4;
	localparam int FEXP_SCALE_LATCH_BIT = 11;
	localparam int FEXP_STATUS_INV_BIT = 13;
	localparam int PEXP_SCALE_ZERO_BIT = 0;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// latch delay trim timing
	localparam int TRIM_STEP_NS = 25;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TRIM_MAX_STEPS = 2000;

	// version gates
	localparam int VER_BOTH_EDGES = 7;
	localparam int VER_SCALE_ZERO_SEMI = 8;

	// host register map
	localparam logic [7:0] HOST_INDEX = 8'h00;
	localparam logic [7:0] HOST_WDATA = 8'h04;
	localparam logic [7:0] HOST_CMD = 8'h08;
	localparam logic [7:0] HOST_RDATA = 8'h0C;
	localparam logic [7:0] HOST_STATUS = 8'h10;
	localparam logic [7:0] HOST_ASSIGN = 8'h14;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;

endpackage

/* File: probe_link_if.sv */
`timescale 1ns/1ps
interface probe_link_if;
	logic [15:0] obj_index;
	logic [31:0] obj_wdata;
	logic obj_wr;
	logic obj_rd;
	logic [31:0] obj_rdata;
	logic assign_five;
	logic assign_six;

	modport device (
		input obj_index, obj_wdata, obj_wr, obj_rd, assign_five, assign_six,
		output obj_rdata
	);
	modport master (
		output obj_index, obj_wdata, obj_wr, obj_rd, assign_five, assign_six,
		input obj_rdata
	);
endinterface

/* File: position_latch_device.sv */
// Functional notes
// R1 - trigger select bit picks input or zero-phase
// R2 - zero-phase source follows semi or fully closed
// R3 - version 8 allows scale zero in semi-closed
// R4 - master assigns probe inputs to general inputs
// R5 - homing without input assignment raises error
// R6 - probe high and low phases last 2 ms
// R7 - master keeps velocity low near input trigger
// R8 - zero-phase with absolute scale raises error
// R9 - no falling edge with zero-phase trigger
// R10 - init or homing entry disables and clears status
// R11 - both edges together only from version 7
// R12 - no maintenance operations while probe active
// R13 - scale monitor and latch bits add scale capture
// R14 - setup bit 13 inverts stored status bits
// R15 - main objects hold scale or encoder feedback
// R16 - signed 25 ns trims delay the capture
// R17 - captured values are read-only signed words
// R18 - status shows active and stored flags
// R19 - control bits 4 and 5 pick edges
// R20 - synchronise, detect edge, store with flag
// R21 - first event holds, continuous overwrites
`timescale 1ns/1ps
module position_latch_device
	import position_latch_pkg::*;
#(
	parameter int ENH_VERSION = 8 // enhanced software version level
) (
	input wire logic sys_clk, // 25 MHz clock
	input wire logic srst, // synchronous reset, active high
	input wire logic clk_en, // freezes all state while low, except the delay counters, which init or homing entry still clears
	input wire logic probe_one_input, // probe one pin
	input wire logic probe_two_input, // probe two pin
	input wire logic encoder_zero_pulse, // encoder one-turn zero pin
	input wire logic scale_zero_pulse, // incremental scale zero pin
	input wire logic [31:0] encoder_position, // encoder feedback_position
	input wire logic [31:0] scale_position, // scale feedback_position
	input wire logic fully_closed, // fully-closed control active
	input wire logic absolute_scale, // scale is absolute type
	input wire logic esm_init, // communication_state_machine in init
	input wire logic homing_mode, // operating mode is homing_mode
	input wire logic homing_start, // homing started, one-cycle pulse
	output logic improper_operation_error, // sticky protection error
	probe_link_if.device link // object access from the master
);

	// writable objects and the monitor zero base
	logic [31:0] func_exp3;
	logic [15:0] trim_one;
	logic [15:0] comm_probe_one_input;
	logic [15:0] trim_two;
	logic [15:0] probe_exp;
	logic [15:0] probe_ctrl;
	logic [31:0] scale_base;

	// captured values: index is probe*2 + edge (0 rise, 1 fall)
	logic [31:0] main_val [4];
	logic [31:0] scale_val [4];
	logic [3:0] stored;

	// pin synchronisers: probe one, probe two, encoder zero, scale zero
	logic [3:0] pin_raw;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_lvl;
	logic [3:0] next_pin_lvl;
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;

	// capture delay per probe
	logic [1:0] pend;
	logic [1:0] pend_edge;
	logic [10:0] cnt [2];
	logic [1:0] hit;
	logic [1:0] hit_edge;
	logic [1:0] cap;
	logic [1:0] cap_edge;
	logic [10:0] dly [2];

	logic homing_d;
	logic disable_all;
	logic scale_zero_sel;
	logic zero_rise;
	logic zero_fall;
	logic scale_latch_on;
	logic [31:0] main_src;
	logic status_inv;
	logic [15:0] status_word;
	logic [31:0] scale_mon;
	logic [31:0] rd_val;
	logic err_set;
	logic ctrl_wr;

	// trim setting to whole cycles; negative trims cannot reach back, so they act as zero
	function automatic logic [10:0] trim_cycles(input logic [15:0] t);
		logic signed [31:0] w;
		w = {{16{t[15]}}, t};
		if (w > TRIM_MAX_STEPS) begin
			w = TRIM_MAX_STEPS;
		end
		if (w < 0) begin
			w = 0;
		end
		w = (w * TRIM_STEP_NS) / CLK_PERIOD_NS;
		return w[10:0];
	endfunction

	function automatic logic obj_wr_hit(input logic [15:0] idx);
		return link.obj_wr && (link.obj_index == idx);
	endfunction

	// a change counts once the second and third stage agree
	assign pin_raw = {scale_zero_pulse, encoder_zero_pulse, probe_two_input, probe_one_input};
	assign next_pin_lvl = (sync2 & sync3) | (pin_lvl & (sync2 ^ sync3)); // R20
	assign pin_rise = next_pin_lvl & ~pin_lvl;
	assign pin_fall = pin_lvl & ~next_pin_lvl;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
			pin_lvl <= 4'h0;
		end else if (clk_en) begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= next_pin_lvl;
		end
	end

	// zero-phase source and feedback routing
	assign scale_zero_sel = fully_closed // R2
		| ((ENH_VERSION >= VER_SCALE_ZERO_SEMI) & probe_exp[PEXP_SCALE_ZERO_BIT]); // R3
	assign zero_rise = scale_zero_sel ? pin_rise[3] : pin_rise[2]; // R2
	assign zero_fall = scale_zero_sel ? pin_fall[3] : pin_fall[2];
	assign main_src = fully_closed ? scale_position : encoder_position; // R15
	assign scale_latch_on = ~fully_closed & comm_probe_one_input[COMM_SCALE_MON_BIT]
		& func_exp3[FEXP_SCALE_LATCH_BIT]; // R13
	assign disable_all = esm_init | (homing_mode & ~homing_d); // R10
	assign ctrl_wr = obj_wr_hit(IDX_PROBE_CTRL);
	assign dly[0] = trim_cycles(trim_one); // R16
	assign dly[1] = trim_cycles(trim_two); // R16

	// per-probe edge qualification
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_probe
			wire [7:0] ctl = probe_ctrl[p*CTL_PROBE_STRIDE +: 8];
			wire t_rise = ctl[CTL_ZSEL] ? zero_rise : pin_rise[p]; // R1
			wire t_fall = ctl[CTL_ZSEL] ? zero_fall : pin_fall[p]; // R1
			// older versions ignore the falling edge if both were set
			wire fall_ok = ctl[CTL_FALL] & ((ENH_VERSION >= VER_BOTH_EDGES) | ~ctl[CTL_RISE]); // R11
			wire q_rise = ctl[CTL_RISE] & t_rise & (ctl[CTL_CONT] | ~stored[p*2]); // R19 R21
			wire q_fall = fall_ok & t_fall & (ctl[CTL_CONT] | ~stored[p*2+1]); // R19 R21
			assign hit[p] = ctl[CTL_ENABLE] & ~pend[p] & (q_rise | q_fall);
			assign hit_edge[p] = ~q_rise;
			assign cap[p] = (hit[p] & (dly[p] == 11'h000)) | (pend[p] & (cnt[p] == 11'h001)); // R16
			assign cap_edge[p] = pend[p] ? pend_edge[p] : hit_edge[p];
		end
	endgenerate

	// delay counters
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (srst || disable_all) begin
				pend[i] <= 1'b0;
				pend_edge[i] <= 1'b0;
				cnt[i] <= 11'h000;
			end else if (clk_en) begin
				if (hit[i] && dly[i] != 11'h000) begin
					pend[i] <= 1'b1;
					pend_edge[i] <= hit_edge[i];
					cnt[i] <= dly[i];
				end else if (pend[i]) begin
					pend[i] <= (cnt[i] != 11'h001);
					cnt[i] <= cnt[i] - 11'h001;
				end
			end
		end
	end

	// value store and flags; a capture wins over a control-write clear in the same cycle, and an init or homing entry clear wins over a capture
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stored <= 4'h0;
			for (int k = 0; k < 4; k++) begin
				main_val[k] <= RST_WORD;
				scale_val[k] <= RST_WORD;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 2; i++) begin
				if (disable_all) begin
					stored[i*2 +: 2] <= 2'h0; // R10
				end else if (cap[i]) begin
					stored[i*2 + int'(cap_edge[i])] <= 1'b1; // R20
					main_val[i*2 + int'(cap_edge[i])] <= main_src; // R20
					if (scale_latch_on) begin
						scale_val[i*2 + int'(cap_edge[i])] <= scale_position; // R13
					end
				end else if (ctrl_wr && link.obj_wdata[i*CTL_PROBE_STRIDE + CTL_ENABLE] != 1'b1) begin
					stored[i*2 +: 2] <= 2'h0;
				end else if (ctrl_wr && !probe_ctrl[i*CTL_PROBE_STRIDE + CTL_ENABLE]) begin
					stored[i*2 +: 2] <= 2'h0; // fresh start on enable
				end
			end
		end
	end

	// setup objects; entering init or homing turns both probes off
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			func_exp3 <= RST_WORD;
			trim_one <= RST_HALF;
			comm_probe_one_input <= RST_HALF;
			trim_two <= RST_HALF;
			probe_exp <= RST_HALF;
			probe_ctrl <= RST_HALF;
			homing_d <= 1'b0;
		end else if (clk_en) begin
			homing_d <= homing_mode;
			if (obj_wr_hit(IDX_FUNC_EXP3)) func_exp3 <= link.obj_wdata;
			if (obj_wr_hit(IDX_TRIM_ONE)) trim_one <= link.obj_wdata[15:0];
			if (obj_wr_hit(IDX_COMM_PROBE_ONE_INPUT)) comm_probe_one_input <= link.obj_wdata[15:0];
			if (obj_wr_hit(IDX_TRIM_TWO)) trim_two <= link.obj_wdata[15:0];
			if (obj_wr_hit(IDX_PROBE_EXP)) probe_exp <= link.obj_wdata[15:0];
			if (disable_all) begin
				probe_ctrl <= RST_HALF; // R10
			end else if (ctrl_wr) begin
				probe_ctrl <= link.obj_wdata[15:0];
			end
		end
	end

	// monitor zero clear: base follows the scale while clearing is on
	assign scale_mon = scale_position - scale_base;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scale_base <= RST_WORD;
		end else if (clk_en && probe_ctrl[CTL_SCALE_CLEAR]) begin
			scale_base <= scale_position;
		end
	end

	// protection error, cleared only by init; a new cause wins over the clear
	assign err_set = (homing_start & ~(link.assign_five & link.assign_six)) // R5
		| (fully_closed & absolute_scale & ((probe_ctrl[CTL_ENABLE] & probe_ctrl[CTL_ZSEL])
		| (probe_ctrl[CTL_PROBE_STRIDE + CTL_ENABLE] & probe_ctrl[CTL_PROBE_STRIDE + CTL_ZSEL]))); // R8
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			improper_operation_error <= 1'b0;
		end else if (clk_en) begin
			improper_operation_error <= err_set | (improper_operation_error & ~esm_init);
		end
	end

	// status word with optional inversion of the stored flags
	assign status_inv = func_exp3[FEXP_STATUS_INV_BIT];
	assign status_word = {5'h00, stored[3] ^ status_inv, stored[2] ^ status_inv, // R14
		probe_ctrl[CTL_PROBE_STRIDE + CTL_ENABLE], 5'h00, stored[1] ^ status_inv,
		stored[0] ^ status_inv, probe_ctrl[CTL_ENABLE]}; // R18

	// read selection; unknown indexes read zero
	assign rd_val = (link.obj_index == IDX_FUNC_EXP3) ? func_exp3 :
		(link.obj_index == IDX_TRIM_ONE) ? {{16{trim_one[15]}}, trim_one} :
		(link.obj_index == IDX_COMM_PROBE_ONE_INPUT) ? {{16{comm_probe_one_input[15]}}, comm_probe_one_input} :
		(link.obj_index == IDX_TRIM_TWO) ? {{16{trim_two[15]}}, trim_two} :
		(link.obj_index == IDX_PROBE_EXP) ? {16'h0000, probe_exp} :
		(link.obj_index == IDX_SCALE_MON) ? scale_mon :
		(link.obj_index == IDX_SCALE_TOTAL) ? scale_mon :
		(link.obj_index == IDX_SCALE_P1_RISE) ? scale_val[0] :
		(link.obj_index == IDX_SCALE_P1_FALL) ? scale_val[1] :
		(link.obj_index == IDX_SCALE_P2_RISE) ? scale_val[2] :
		(link.obj_index == IDX_SCALE_P2_FALL) ? scale_val[3] :
		(link.obj_index == IDX_PROBE_CTRL) ? {16'h0000, probe_ctrl} :
		(link.obj_index == IDX_PROBE_STATUS) ? {16'h0000, status_word} :
		(link.obj_index == IDX_P1_RISE) ? main_val[0] : // R17
		(link.obj_index == IDX_P1_FALL) ? main_val[1] :
		(link.obj_index == IDX_P2_RISE) ? main_val[2] :
		(link.obj_index == IDX_P2_FALL) ? main_val[3] : RST_WORD;

	// read data stands from the cycle after the read until the next read
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			link.obj_rdata <= RST_WORD;
		end else if (clk_en && link.obj_rd) begin
			link.obj_rdata <= rd_val;
		end
	end

endmodule

/* File: position_latch_host.sv */
`timescale 1ns/1ps
module position_latch_host
	import position_latch_pkg::*;
(
	input wire logic sys_clk, // 25 MHz clock
	input wire logic srst, // synchronous reset, active high
	input wire logic clk_en, // freezes all state while low
	input wire logic [7:0] reg_addr, // software register address
	input wire logic [31:0] reg_wdata, // software write data
	input wire logic reg_wr, // software write strobe
	input wire logic reg_rd, // software read strobe
	output logic [31:0] reg_rdata, // read data, cycle after reg_rd
	probe_link_if.master link // object access to the device
);

	logic [15:0] index;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic rd_wait;
	logic rd_done;
	logic [1:0] assign_bits;
	logic [15:0] ctrl_shadow;
	logic probe_active;
	logic [31:0] safe_wdata;
	logic [31:0] user_val;
	logic issue_wr;
	logic issue_rd;

	assign issue_wr = reg_wr && reg_addr == HOST_CMD && reg_wdata[CMD_WRITE_BIT];
	assign issue_rd = reg_wr && reg_addr == HOST_CMD && reg_wdata[CMD_READ_BIT] && !issue_wr;
	assign probe_active = ctrl_shadow[CTL_ENABLE] | ctrl_shadow[CTL_PROBE_STRIDE + CTL_ENABLE];

	// falling edge is stripped where the zero phase triggers
	assign safe_wdata = (index != IDX_PROBE_CTRL) ? wdata :
		wdata & ~{16'h0000, 2'h0, wdata[CTL_PROBE_STRIDE + CTL_ZSEL], 7'h00,
		wdata[CTL_ZSEL], 5'h00}; // R9

	// command staging and link strobes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			index <= RST_HALF;
			wdata <= RST_WORD;
			link.obj_index <= RST_HALF;
			link.obj_wdata <= RST_WORD;
			link.obj_wr <= 1'b0;
			link.obj_rd <= 1'b0;
			ctrl_shadow <= RST_HALF;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == HOST_INDEX) index <= reg_wdata[15:0];
			if (reg_wr && reg_addr == HOST_WDATA) wdata <= reg_wdata;
			link.obj_wr <= issue_wr;
			link.obj_rd <= issue_rd;
			if (issue_wr || issue_rd) begin
				link.obj_index <= index;
				link.obj_wdata <= safe_wdata;
			end
			if (issue_wr && index == IDX_PROBE_CTRL) ctrl_shadow <= safe_wdata[15:0];
		end
	end

	// input assignment is frozen while a probe runs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			assign_bits <= 2'h0;
			link.assign_five <= 1'b0;
			link.assign_six <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == HOST_ASSIGN && !probe_active) begin
				assign_bits <= reg_wdata[1:0]; // R12
			end
			link.assign_five <= assign_bits[0]; // R4
			link.assign_six <= assign_bits[1]; // R4
		end
	end

	// device answers one cycle after its read strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_wait <= 1'b0;
			rd_done <= 1'b0;
			rdata <= RST_WORD;
		end else if (clk_en) begin
			rd_wait <= link.obj_rd;
			if (rd_wait) begin
				rdata <= link.obj_rdata;
				rd_done <= 1'b1;
			end else if (issue_rd) begin
				rd_done <= 1'b0;
			end
		end
	end

	assign user_val = (reg_addr == HOST_INDEX) ? {16'h0000, index} :
		(reg_addr == HOST_WDATA) ? wdata :
		(reg_addr == HOST_RDATA) ? rdata :
		(reg_addr == HOST_STATUS) ? {29'h0, probe_active, rd_wait | link.obj_rd, rd_done} :
		(reg_addr == HOST_ASSIGN) ? {30'h0, assign_bits} : RST_WORD;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= RST_WORD;
		end else if (clk_en && reg_rd) begin
			reg_rdata <= user_val;
		end
	end

endmodule

/* File: probe_link_props.sv */
`timescale 1ns/1ps
module probe_link_props
	import position_latch_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic srst, // sync reset
	input wire logic [15:0] obj_index, // object index
	input wire logic [31:0] obj_wdata, // write data
	input wire logic obj_wr, // write pulse
	input wire logic obj_rd, // read pulse
	input wire logic [31:0] obj_rdata, // read data
	input wire logic assign_five, // input five mapped
	input wire logic assign_six // input six mapped
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_excl; !(obj_wr && obj_rd); endproperty
	a_excl: assert property (p_excl) else $error("link read and write at once");
	property p_wr_pulse; obj_wr |=> !obj_wr && !obj_rd; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("link write not a single pulse");
	property p_rd_pulse; obj_rd |=> !obj_rd && !obj_wr; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("link read not a single pulse");
	// read data may only move in the cycle after a read
	property p_rdata_hold; !$past(obj_rd) |-> $stable(obj_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_unknown_zero; obj_rd && obj_index == 16'h0001 |=> obj_rdata == 32'h0000_0000; endproperty
	a_unknown_zero: assert property (p_unknown_zero) else $error("unknown index not zero");
	property p_status_rsv; obj_rd && obj_index == IDX_PROBE_STATUS |=> obj_rdata[31:11] == 21'h0 && obj_rdata[7:3] == 5'h00;
	endproperty
	a_status_rsv: assert property (p_status_rsv) else $error("status reserved bits set");
	property p_ctrl_zext; obj_rd && obj_index == IDX_PROBE_CTRL |=> obj_rdata[31:16] == 16'h0000; endproperty
	a_ctrl_zext: assert property (p_ctrl_zext) else $error("control not zero-extended");
	property p_trim_sext; obj_rd && obj_index == IDX_TRIM_ONE |=> obj_rdata[31:16] == {16{obj_rdata[15]}}; endproperty
	a_trim_sext: assert property (p_trim_sext) else $error("trim not sign-extended");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb
	import position_latch_pkg::*;
;
	logic sys_clk, srst, ce, fc, abs_s, communication_state_machine, hm, hs, err, reg_wr, reg_rd;
	logic [3:0] pins; // probe one, probe two, encoder zero, scale zero
	logic [31:0] enc, scl, reg_wdata, reg_rdata, d, pa, pb;
	logic [7:0] reg_addr;
	int num_errors, n_tests, seed, i;
	localparam logic [31:0] SK = 32'h5A5A_0000; // scale is the encoder value XOR this
	probe_link_if link_if();
	position_latch_device position_latch_device_i(.sys_clk, .srst, .clk_en(ce), .probe_one_input(pins[0]),
		.probe_two_input(pins[1]), .encoder_zero_pulse(pins[2]), .scale_zero_pulse(pins[3]),
		.encoder_position(enc), .scale_position(scl), .fully_closed(fc), .absolute_scale(abs_s),
		.esm_init(communication_state_machine), .homing_mode(hm), .homing_start(hs), .improper_operation_error(err), .link(link_if.device));
	position_latch_host position_latch_host_i(.sys_clk, .srst, .clk_en(ce), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .link(link_if.master));
	probe_link_props probe_link_props_i(.sys_clk, .srst, .obj_index(link_if.obj_index), .obj_wdata(link_if.obj_wdata),
		.obj_wr(link_if.obj_wr), .obj_rd(link_if.obj_rd), .obj_rdata(link_if.obj_rdata),
		.assign_five(link_if.assign_five), .assign_six(link_if.assign_six));
	always #20 sys_clk = ~sys_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// object access through the host: index, data, command
	task automatic oset(input logic [15:0] idx, input logic [31:0] v);
		wr(HOST_INDEX, {16'h0000, idx});
		wr(HOST_WDATA, v);
		wr(HOST_CMD, 32'h0000_0001);
		tick(6);
	endtask
	task automatic oread(input logic [15:0] idx, output logic [31:0] v);
		wr(HOST_INDEX, {16'h0000, idx});
		wr(HOST_CMD, 32'h0000_0002);
		tick(6);
		rd(HOST_RDATA, v);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// pin change with the feedback set in the same cycle and held still for 12 cycles after it
	// phase of 12 cycles covers the synchroniser; the real minimum is cut to keep the run short
	task automatic trig(input int w, input logic lvl, input logic [31:0] p);
		@(posedge sys_clk);
		enc <= p;
		scl <= p ^ SK;
		pins[w] <= lvl;
		tick(12);
	endtask
	// rising edge, feedback moves from p to q twelve cycles later
	task automatic dtrig(input logic [31:0] p, input logic [31:0] q);
		trig(0, 1'b0, p);
		trig(0, 1'b1, p);
		enc <= q;
		tick(60);
	endtask
	function automatic logic [31:0] st(input logic [15:0] c, input logic [15:0] f, input logic inv);
		st = {16'h0000, (c & 16'h0101) | (f ^ (inv ? 16'h0606 : 16'h0000))};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog sized well beyond the sequence length
	initial begin
		tick(30000);
		num_errors++;
		$display("BAD %0t: watchdog expired", $time);
		results();
	end
	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		{fc, abs_s, communication_state_machine, hm, hs, reg_wr, reg_rd} = 7'h00;
		pins = 4'h0;
		enc = 32'h0;
		scl = 32'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		seed = 59;
		ce = 1'b1;
		tick(4);
		srst <= 1'b0;
		oread(IDX_PROBE_STATUS, d); chk(d, 32'h0);
		oread(IDX_P1_RISE, d); chk(d, 32'h0);
		oread(16'h0001, d); chk(d, 32'h0);
		// homing with no input map, then init clears the cause-free error
		@(posedge sys_clk) hs <= 1'b1;
		@(posedge sys_clk) hs <= 1'b0;
		tick(4); #1 chk({31'h0, err}, 32'h1);
		@(posedge sys_clk) communication_state_machine <= 1'b1;
		tick(2); communication_state_machine <= 1'b0;
		tick(4); #1 chk({31'h0, err}, 32'h0);
		$display("test reset and map error done");
		wr(HOST_ASSIGN, 32'h0000_0003);
		oset(IDX_PROBE_CTRL, 32'h0011);
		pa = $random(seed);
		trig(0, 1'b1, pa);
		trig(0, 1'b0, $random(seed));
		oread(IDX_P1_RISE, d); chk(d, pa);
		oread(IDX_P1_FALL, d); chk(d, 32'h0);
		oread(IDX_PROBE_STATUS, d); chk(d, st(16'h0011, 16'h0002, 1'b0));
		trig(0, 1'b1, $random(seed));
		oread(IDX_P1_RISE, d); chk(d, pa);
		oset(IDX_PROBE_CTRL, 32'h0013);
		trig(0, 1'b0, $random(seed));
		pb = $random(seed);
		trig(0, 1'b1, pb);
		oread(IDX_P1_RISE, d); chk(d, pb);
		oset(IDX_P1_RISE, 32'h1234_5678);
		oread(IDX_P1_RISE, d); chk(d, pb);
		$display("test rise capture and event modes done");
		oset(IDX_PROBE_CTRL, 32'h0000);
		oset(IDX_PROBE_CTRL, 32'h0031);
		pa = $random(seed);
		pb = $random(seed);
		trig(0, 1'b0, pa);
		trig(0, 1'b1, pb);
		oread(IDX_P1_FALL, d); chk(d, pa);
		oread(IDX_P1_RISE, d); chk(d, pb);
		oread(IDX_PROBE_STATUS, d); chk(d, st(16'h0031, 16'h0006, 1'b0));
		oset(IDX_FUNC_EXP3, 32'h0000_2000);
		oread(IDX_PROBE_STATUS, d); chk(d, st(16'h0031, 16'h0006, 1'b1));
		oset(IDX_FUNC_EXP3, 32'h0000_0000);
		$display("test both edges and inversion done");
		// probe two on the zero phase: encoder zero semi-closed, scale zero fully-closed
		for (i = 0; i < 2; i++) begin
			fc <= i[0];
			oset(IDX_PROBE_CTRL, 32'h0000);
			oset(IDX_PROBE_CTRL, 32'h1500);
			trig(1, 1'b1, $random(seed));
			trig(1, 1'b0, $random(seed));
			pa = $random(seed);
			trig(2 + i, 1'b1, pa);
			trig(2 + i, 1'b0, $random(seed));
			oread(IDX_P2_RISE, d); chk(d, (i == 1) ? pa ^ SK : pa);
		end
		abs_s <= 1'b1;
		tick(4); #1 chk({31'h0, err}, 32'h1);
		abs_s <= 1'b0;
		$display("test trigger select done");
		// init, then homing entry, each disable and clear
		for (i = 0; i < 2; i++) begin
			oset(IDX_PROBE_CTRL, 32'h0011);
			@(posedge sys_clk) {hm, communication_state_machine} <= (i == 0) ? 2'b01 : 2'b10;
			tick(3); {hm, communication_state_machine} <= 2'b00;
			oread(IDX_PROBE_STATUS, d); chk(d, 32'h0);
			oread(IDX_PROBE_CTRL, d); chk(d, 32'h0);
		end
		#1 chk({31'h0, err}, 32'h0);
		fc <= 1'b0;
		$display("test init and homing clear done");
		// delay trim 80 steps moves the capture 50 cycles later; negative acts as zero
		oset(IDX_TRIM_ONE, 32'h0000_0050);
		oread(IDX_TRIM_ONE, d); chk(d, 32'h0000_0050);
		oset(IDX_PROBE_CTRL, 32'h0013);
		pa = $random(seed);
		pb = $random(seed);
		dtrig(pa, pb);
		oread(IDX_P1_RISE, d); chk(d, pb);
		oset(IDX_TRIM_ONE, 32'h0000_FFB0);
		oread(IDX_TRIM_ONE, d); chk(d, 32'hFFFF_FFB0);
		pa = $random(seed);
		pb = $random(seed);
		dtrig(pa, pb);
		oread(IDX_P1_RISE, d); chk(d, pa);
		// frozen clock enable: an edge made while frozen is only seen after the thaw
		pa = $random(seed);
		pb = $random(seed);
		trig(0, 1'b0, pa);
		ce <= 1'b0;
		trig(0, 1'b1, pa);
		enc <= pb;
		ce <= 1'b1;
		tick(12);
		oread(IDX_P1_RISE, d); chk(d, pb);
		$display("test latch delay trim and freeze done");
		// semi-closed with the scale zero chosen and scale latching on
		oset(IDX_COMM_PROBE_ONE_INPUT, 32'h0000_0010);
		oset(IDX_FUNC_EXP3, 32'h0000_0800);
		oset(IDX_PROBE_EXP, 32'h0000_0001);
		oset(IDX_PROBE_CTRL, 32'h0000);
		oset(IDX_PROBE_CTRL, 32'h1500);
		pa = $random(seed);
		trig(2, 1'b1, $random(seed));
		trig(2, 1'b0, $random(seed));
		trig(3, 1'b1, pa);
		trig(3, 1'b0, $random(seed));
		oread(IDX_P2_RISE, d); chk(d, pa);
		oread(IDX_SCALE_P2_RISE, d); chk(d, pa ^ SK);
		$display("test scale zero and scale latch done");
		results();
	end
endmodule
